// ### logic/moo_ao_sat.sv
// Purpose: Clamp a written word to the 12-bit analog code range
// Assumes: Unsigned write data
// Notes:   Purely combinational
`default_nettype none
`include "moo_params.svh"
module moo_ao_sat (
  // Write data
  input  wire logic [31:0]        wrWord,
  // Clamped code
  output var moo_pkg::moo_code_t  code
);
  import moo_pkg::*;

  // Values beyond the top code load the top code
  always_comb begin
    if (wrWord > `MOO_AO_MAX32) begin
      code = `MOO_AO_MAX;
    end else begin
      code = wrWord[11:0];
    end
  end
endmodule
`default_nettype wire

// ### logic/moo_out_sel.sv
// Purpose: Choose automatic or manual value for each output
// Assumes: Setpoint vectors indexed from setpoint one at bit 0
// Notes:   Purely combinational
`default_nettype none
module moo_out_sel (
  // Automatic sources
  input  wire logic [3:0]         autoSp,
  input  wire logic [3:0]         offMask,
  input  wire logic [11:0]        autoAo,
  // Manual sources
  input  wire logic [3:0]         holdSp,
  input  wire logic [11:0]        holdAo,
  // Per-output manual selects
  input  wire logic [3:0]         manSp,
  input  wire logic               manAo,
  // Selected values
  output logic [3:0]              spNext,
  output logic [11:0]             aoNext
);
  import moo_pkg::*;

  // One selector per setpoint output
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_sp
      assign spNext[i] = manSp[i] ? holdSp[i]
                                  : (autoSp[i] & ~offMask[i]);
    end
  endgenerate

  // Analog output takes the held code in manual
  assign aoNext = manAo ? holdAo : autoAo;
endmodule
`default_nettype wire

// ### logic/moo_params.svh
// Purpose: Constants for the manual output override register bank
// Assumes: Register indices counted in four-byte data blocks
// Notes:   Definitions only
`ifndef MOO_PARAMS_SVH
`define MOO_PARAMS_SVH

// Register indices, single-mode variant
`define MOO_IDX_AO_SINGLE 5'h08
`define MOO_IDX_CTRL      5'h09
// Register indices, per-output mode variants
`define MOO_IDX_MODE      5'h10
`define MOO_IDX_AO        5'h11
`define MOO_IDX_SPSTATE   5'h12

// Control register fields
`define MOO_CTRL_MODE_BIT 4
`define MOO_CTRL_SENS_BIT 6
// Mode register fields
`define MOO_MODE_AO_BIT   0
`define MOO_MODE_W_ANA    5
`define MOO_MODE_W_CLK    4

// Analog code limit and reset values
`define MOO_AO_MAX        12'hFFF
`define MOO_AO_MAX32      32'h0000_0FFF
`define MOO_AO_RST        12'h000
`define MOO_SP_RST        4'h0
`define MOO_MODE_RST      5'h00
`define MOO_RD_RST        32'h0000_0000

`endif

// ### logic/moo_pkg.sv
// Purpose: Types shared by the manual output override register bank
// Assumes: Nothing beyond the constants header
// Notes:   Variant selects register layout
`default_nettype none
package moo_pkg;
  // Meter variant that fixes the register layout
  typedef enum logic [1:0] {
    MOO_SINGLE = 2'b00,
    MOO_MULTI  = 2'b01,
    MOO_CLOCK  = 2'b10
  } moo_variant_e;

  // Register selected by a bus index
  typedef enum logic [2:0] {
    MOO_SEL_NONE = 3'b000,
    MOO_SEL_CTRL = 3'b001,
    MOO_SEL_MODE = 3'b010,
    MOO_SEL_SP   = 3'b011,
    MOO_SEL_AO   = 3'b100
  } moo_sel_e;

  typedef logic [11:0] moo_code_t;
endpackage
`default_nettype wire

// ### logic/moo_regs.sv
// Purpose: Manual override registers for setpoint and analog outputs
// Assumes: One-cycle read and write strobes synchronous to sys_clk
// Notes:   Read data appear one cycle after the read strobe
`default_nettype none
`include "moo_params.svh"

module moo_regs #(
  parameter moo_pkg::moo_variant_e VARIANT     = moo_pkg::MOO_MULTI,
  parameter bit                    TEMP_SENSOR = 1'b0
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               srst,
  // Register port
  input  wire logic               regRead,
  input  wire logic               regWrite,
  input  wire logic [4:0]         regIndex,
  input  wire logic [31:0]        regWdata,
  output logic [31:0]             regRdata,
  output logic                    regRvalid,
  // Internal control sources
  input  wire logic [3:0]         autoSetpoint,
  input  wire logic [11:0]        autoAnalog,
  input  wire logic               sensorFail,
  // Driven outputs
  output logic [3:0]              setpointOut,
  output var moo_pkg::moo_code_t  analogLevel
);
  import moo_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Swap setpoint order between bus layout and internal layout
  function automatic logic [3:0] rev4(input logic [3:0] v);
    rev4 = {v[0], v[1], v[2], v[3]};
  endfunction

  // Map a register index to a register for this variant
  function automatic moo_sel_e decode(input logic [4:0] idx);
    decode = MOO_SEL_NONE;
    if (VARIANT == MOO_SINGLE) begin
      if (idx == `MOO_IDX_CTRL)      decode = MOO_SEL_CTRL;
      if (idx == `MOO_IDX_AO_SINGLE) decode = MOO_SEL_AO;
    end else begin
      if (idx == `MOO_IDX_MODE)      decode = MOO_SEL_MODE;
      if (idx == `MOO_IDX_SPSTATE)   decode = MOO_SEL_SP;
      if (idx == `MOO_IDX_AO && VARIANT == MOO_MULTI) begin
        decode = MOO_SEL_AO;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  logic        ctrlManual_reg, ctrlManual_next;
  logic [4:0]  mode_reg, mode_next;
  logic [3:0]  holdSp_reg, holdSp_next;
  logic [11:0] holdAo_reg, holdAo_next;
  logic [11:0] shadowAo_reg, shadowAo_next;
  logic        pendAo_reg, pendAo_next;
  logic [3:0]  offMask_reg, offMask_next;
  logic [3:0]  manSpPrev_reg;
  logic        manAoPrev_reg;
  logic [3:0]  spOut_reg;
  logic [11:0] aoOut_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic        rvalid_reg;

  logic [3:0]  manSp;
  logic        manAo;
  logic [3:0]  spNext;
  logic [11:0] aoNext;
  logic [11:0] satCode;
  moo_sel_e    wrSel;
  moo_sel_e    rdSel;
  logic [4:0]  modeMask;

  assign wrSel    = regWrite ? decode(regIndex) : MOO_SEL_NONE;
  assign rdSel    = decode(regIndex);
  assign modeMask = (VARIANT == MOO_CLOCK) ? 5'h0F : 5'h1F;

  // Per-output manual selects from the active mode source
  always_comb begin
    case (VARIANT)
      MOO_SINGLE: begin
        manSp = {4{ctrlManual_reg}};
        manAo = ctrlManual_reg;
      end
      MOO_MULTI: begin
        manSp = rev4(mode_reg[4:1]);
        manAo = mode_reg[`MOO_MODE_AO_BIT];
      end
      MOO_CLOCK: begin
        manSp = rev4(mode_reg[3:0]);
        manAo = 1'b0;
      end
      default: begin
        manSp = 4'h0;
        manAo = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Clamp analog write data
  moo_ao_sat u_sat (
    .wrWord (regWdata),
    .code   (satCode)
  );

  // Output selection
  moo_out_sel u_sel (
    .autoSp  (autoSetpoint),
    .offMask (offMask_reg),
    .autoAo  (autoAnalog),
    .holdSp  (holdSp_reg),
    .holdAo  (holdAo_reg),
    .manSp   (manSp),
    .manAo   (manAo),
    .spNext  (spNext),
    .aoNext  (aoNext)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register writes and manual hold values

  always_comb begin
    ctrlManual_next = ctrlManual_reg;
    mode_next       = mode_reg;
    holdSp_next     = holdSp_reg;
    holdAo_next     = holdAo_reg;
    shadowAo_next   = shadowAo_reg;
    pendAo_next     = pendAo_reg;
    // Turn-off requests re-arm once the automatic source drops
    offMask_next    = offMask_reg & autoSetpoint;
    // Hold values track the driven value while automatic, except single-mode setpoints and a pending analog write, so the first
    // manual cycle repeats the last output instead of a stale hold value
    if (VARIANT != MOO_SINGLE) begin
      holdSp_next = (holdSp_reg & manSp) | (spNext & ~manSp);
    end
    if (!manAo) begin
      holdAo_next = pendAo_reg ? shadowAo_reg : aoNext;
    end
    if (manAo && !manAoPrev_reg) begin
      pendAo_next = 1'b0;
    end
    case (wrSel)
      MOO_SEL_CTRL: begin
        ctrlManual_next = regWdata[`MOO_CTRL_MODE_BIT];
        if (regWdata[`MOO_CTRL_MODE_BIT]) begin
          holdSp_next = regWdata[3:0];
        end else begin
          // Automatic: a written zero only turns an active output off
          offMask_next = offMask_next |
                         (spOut_reg & ~regWdata[3:0]);
        end
      end
      MOO_SEL_MODE: begin
        mode_next = regWdata[4:0] & modeMask;
      end
      MOO_SEL_SP: begin
        // Only outputs in manual take the written state
        holdSp_next = (holdSp_next & ~manSp) |
                      (rev4(regWdata[3:0]) & manSp);
      end
      MOO_SEL_AO: begin
        if (manAo) begin
          holdAo_next = satCode;
        end else begin
          shadowAo_next = satCode;
          pendAo_next   = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrlManual_reg <= 1'b0;
      mode_reg       <= `MOO_MODE_RST;
      holdSp_reg     <= `MOO_SP_RST;
      holdAo_reg     <= `MOO_AO_RST;
      shadowAo_reg   <= `MOO_AO_RST;
      pendAo_reg     <= 1'b0;
      offMask_reg    <= `MOO_SP_RST;
      manSpPrev_reg  <= `MOO_SP_RST;
      manAoPrev_reg  <= 1'b0;
    end else begin
      ctrlManual_reg <= ctrlManual_next;
      mode_reg       <= mode_next;
      holdSp_reg     <= holdSp_next;
      holdAo_reg     <= holdAo_next;
      shadowAo_reg   <= shadowAo_next;
      pendAo_reg     <= pendAo_next;
      offMask_reg    <= offMask_next;
      manSpPrev_reg  <= manSp;
      manAoPrev_reg  <= manAo;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and read data

  // Read data; unmapped indices and undefined bits read zero
  always_comb begin
    rdata_next = `MOO_RD_RST;
    case (rdSel)
      MOO_SEL_CTRL: begin
        rdata_next[3:0] = spOut_reg;
        rdata_next[`MOO_CTRL_MODE_BIT] = ctrlManual_reg;
        rdata_next[`MOO_CTRL_SENS_BIT] = TEMP_SENSOR & sensorFail;
      end
      MOO_SEL_MODE: rdata_next[4:0] = mode_reg;
      MOO_SEL_SP:   rdata_next[3:0] = rev4(spOut_reg);
      MOO_SEL_AO:   rdata_next[11:0] = aoOut_reg;
      default:      rdata_next = `MOO_RD_RST;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      spOut_reg  <= `MOO_SP_RST;
      aoOut_reg  <= `MOO_AO_RST;
      rdata_reg  <= `MOO_RD_RST;
      rvalid_reg <= 1'b0;
    end else begin
      spOut_reg  <= spNext;
      aoOut_reg  <= aoNext;
      rdata_reg  <= regRead ? rdata_next : `MOO_RD_RST;
      rvalid_reg <= regRead;
    end
  end

  assign setpointOut = spOut_reg;
  assign analogLevel = aoOut_reg;
  assign regRdata    = rdata_reg;
  assign regRvalid   = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_sat_limit: assert property (
    wrSel == MOO_SEL_AO && manAo && regWdata > `MOO_AO_MAX32
    ##1 manAo |-> ##1 analogLevel == `MOO_AO_MAX)
    else $error("analog write did not saturate");

  a_ao_manual: assert property (
    wrSel == MOO_SEL_AO && manAo ##1 manAo && wrSel != MOO_SEL_AO
    |-> ##1 analogLevel == $past(satCode, 2))
    else $error("manual analog write not applied");

  a_ao_auto: assert property (
    !manAo |-> ##1 analogLevel == $past(autoAnalog))
    else $error("automatic analog not followed");

  a_ctrl_unused: assert property (
    regRead && rdSel == MOO_SEL_CTRL |-> ##1
    regRvalid && !regRdata[5] && !regRdata[7])
    else $error("unused control bits read nonzero");

  a_ctrl_sensor: assert property (
    regRead && rdSel == MOO_SEL_CTRL |-> ##1
    regRdata[6] == (TEMP_SENSOR & $past(sensorFail)))
    else $error("sensor status mismatch");

  a_sp_read: assert property (
    regRead && rdSel == MOO_SEL_SP |-> ##1
    regRdata[3:0] == rev4($past(setpointOut)))
    else $error("setpoint state read mismatch");

  a_hold_entry: assert property (
    VARIANT != MOO_SINGLE && manSp[0] && !manSpPrev_reg[0]
    && wrSel == MOO_SEL_NONE ##1 wrSel == MOO_SEL_NONE
    |-> ##1 setpointOut[0] == $past(setpointOut[0], 2))
    else $error("output not held on manual entry");

  a_manual_ctrl: assert property (
    wrSel == MOO_SEL_CTRL && regWdata[`MOO_CTRL_MODE_BIT]
    ##1 wrSel == MOO_SEL_NONE |-> ##1 setpointOut == $past(regWdata[3:0], 2))
    else $error("manual setpoints not applied");

  a_auto_off: assert property (
    !manSp[0] && offMask_reg[0] |-> ##1 !setpointOut[0])
    else $error("turned-off setpoint came back on");

  a_rsvd_zero: assert property (
    regRvalid |-> regRdata[31:12] == 20'h0_0000)
    else $error("reserved read bits nonzero");

  c_manual_entry: cover property (manAo && !manAoPrev_reg && pendAo_reg);
  c_auto_off: cover property (wrSel == MOO_SEL_CTRL && |offMask_next);
  c_ao_sat: cover property (wrSel == MOO_SEL_AO &&
                            regWdata > `MOO_AO_MAX32);
endmodule
`default_nettype wire

// ### tb/manual_output_override_regs_tb.sv
// Purpose: Self-checking bench for the override register bank
// Assumes: Multi-output, single-mode and clock variants side by side
// Notes:   Host model drives all three banks, read data muxed from two
`default_nettype none
`include "moo_params.svh"
module manual_output_override_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import moo_pkg::*;

  logic        sys_clk, srst, regRead, regWrite, rvM, rvS, selS;
  logic        sensorFail;
  logic [4:0]  regIndex;
  logic [31:0] regWdata, rdM, rdS, rdat, v32;
  logic [3:0]  autoSetpoint, spM, spS, spC, a4;
  logic [11:0] autoAnalog;
  moo_code_t   aoM, aoS, aoC;
  int          errors, comparisons, seed;

  assign rdat = selS ? rdS : rdM;

  moo_host_model moo_host_model_inst (
    .sys_clk(sys_clk), .regRead(regRead), .regWrite(regWrite),
    .regIndex(regIndex), .regWdata(regWdata), .regRdata(rdat),
    .regRvalid(selS ? rvS : rvM));
  moo_regs #(.VARIANT(MOO_MULTI), .TEMP_SENSOR(1'b0)) moo_regs_inst (
    .sys_clk(sys_clk), .srst(srst), .regRead(regRead),
    .regWrite(regWrite), .regIndex(regIndex), .regWdata(regWdata),
    .regRdata(rdM), .regRvalid(rvM), .autoSetpoint(autoSetpoint),
    .autoAnalog(autoAnalog), .sensorFail(sensorFail),
    .setpointOut(spM), .analogLevel(aoM));
  moo_regs #(.VARIANT(MOO_SINGLE), .TEMP_SENSOR(1'b1)) moo_regs_s_inst (
    .sys_clk(sys_clk), .srst(srst), .regRead(regRead),
    .regWrite(regWrite), .regIndex(regIndex), .regWdata(regWdata),
    .regRdata(rdS), .regRvalid(rvS), .autoSetpoint(autoSetpoint),
    .autoAnalog(autoAnalog), .sensorFail(sensorFail),
    .setpointOut(spS), .analogLevel(aoS));
  moo_regs #(.VARIANT(MOO_CLOCK), .TEMP_SENSOR(1'b0)) moo_regs_c_inst (
    .sys_clk(sys_clk), .srst(srst), .regRead(regRead),
    .regWrite(regWrite), .regIndex(regIndex), .regWdata(regWdata),
    .regRdata(), .regRvalid(), .autoSetpoint(autoSetpoint),
    .autoAnalog(autoAnalog), .sensorFail(sensorFail),
    .setpointOut(spC), .analogLevel(aoC));

  ////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [3:0] rev4(input logic [3:0] x);
    return {x[0], x[1], x[2], x[3]};
  endfunction
  function automatic logic [11:0] sat(input logic [31:0] x);
    return (x > 32'h0000_0FFF) ? 12'hFFF : x[11:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick2;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    moo_host_model_inst.wr(idx, d);
    tick2();
  endtask
  // Read and compare, answer must carry a valid pulse
  task automatic rdc(input logic [4:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    moo_host_model_inst.rd(idx, d, v);
    chk(d, exp);
    chk({31'h0, v}, 32'h0000_0001);
  endtask
  task automatic final_report;
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #50us;
    errors++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 14;
    errors = 0;
    comparisons = 0;
    srst = 1'b1;
    selS = 1'b0;
    sensorFail = 1'b1;
    autoSetpoint = 4'hF;
    autoAnalog = 12'hABC;
    repeat (10) @(negedge sys_clk);
    chk({aoS, spS, aoM, spM}, 32'h0000_0000);
    srst = 1'b0;
    // Automatic mode: outputs and reads follow internal control
    repeat (6) begin
      autoSetpoint = 4'($random(seed));
      autoAnalog = 12'($random(seed));
      tick2();
      chk({aoS, spS, aoM, spM}, {2{autoAnalog, autoSetpoint}});
      chk({16'h0, aoC, spC}, {16'h0, autoAnalog, autoSetpoint});
      rdc(`MOO_IDX_SPSTATE, {28'h0, rev4(autoSetpoint)});
      rdc(`MOO_IDX_AO, {20'h0, autoAnalog});
    end
    // Unmapped and other-variant places read zero, ignore writes
    wr(5'h05, 32'hFFFF_FFFF);
    rdc(5'h05, 32'h0000_0000);
    rdc(`MOO_IDX_CTRL, 32'h0000_0000);
    // Analog write in automatic waits for manual
    wr(`MOO_IDX_AO, 32'h0000_0123);
    chk({20'h0, aoM}, {20'h0, autoAnalog});
    a4 = autoSetpoint;
    wr(`MOO_IDX_MODE, 32'h0000_0003);
    chk({20'h0, aoM}, 32'h0000_0123);
    autoSetpoint = ~a4;
    autoAnalog = ~autoAnalog;
    tick2();
    chk({28'h0, spM}, {28'h0, a4[3], ~a4[2:0]});
    chk({20'h0, aoM}, 32'h0000_0123);
    chk({28'h0, spC}, {28'h0, a4[3:2], ~a4[1:0]});
    chk({20'h0, aoC}, {20'h0, autoAnalog});
    wr(`MOO_IDX_AO, 32'h0000_1234);
    chk({20'h0, aoM}, 32'h0000_0FFF);
    rdc(`MOO_IDX_AO, 32'h0000_0FFF);
    // Manual analog follows each written code
    repeat (6) begin
      v32 = $random(seed) & 32'h0000_1FFF;
      wr(`MOO_IDX_AO, v32);
      chk({20'h0, aoM}, {20'h0, sat(v32)});
    end
    wr(`MOO_IDX_AO, 32'h0000_0000);
    chk({20'h0, aoM}, 32'h0000_0000);
    // All setpoints manual, driven by the state register
    wr(`MOO_IDX_MODE, 32'hFFFF_FFFF);
    rdc(`MOO_IDX_MODE, 32'h0000_001F);
    repeat (4) begin
      a4 = 4'($random(seed));
      wr(`MOO_IDX_SPSTATE, {28'hFFF_FFFF, a4});
      chk({28'h0, spM}, {28'h0, rev4(a4)});
      chk({28'h0, spC}, {28'h0, rev4(a4)});
      rdc(`MOO_IDX_SPSTATE, {28'h0, a4});
    end
    // Single-mode bank: control register drives all setpoints and the manual select
    selS = 1'b1;
    wr(`MOO_IDX_CTRL, 32'hFFFF_FF1A);
    chk({28'h0, spS}, 32'h0000_000A);
    rdc(`MOO_IDX_CTRL, 32'h0000_005A);
    wr(`MOO_IDX_AO_SINGLE, 32'h0000_2000);
    chk({20'h0, aoS}, 32'h0000_0FFF);
    wr(`MOO_IDX_AO_SINGLE, 32'h0000_07FF);
    chk({20'h0, aoS}, 32'h0000_07FF);
    // Back to automatic: writes can only switch setpoints off
    sensorFail = 1'b0;
    autoSetpoint = 4'hF;
    wr(`MOO_IDX_CTRL, 32'h0000_000F);
    chk({16'h0, aoS, spS}, {16'h0, autoAnalog, 4'hF});
    wr(`MOO_IDX_CTRL, 32'h0000_0005);
    chk({28'h0, spS}, 32'h0000_0005);
    rdc(`MOO_IDX_CTRL, 32'h0000_0005);
    final_report();
  end
endmodule
`default_nettype wire

// ### tb/moo_host_model.sv
// Purpose: Host model issuing register reads and writes
// Assumes: Strobes change at the falling edge of sys_clk
// Notes:   One transfer at a time, data lines scrambled when idle
`default_nettype none
module moo_host_model (
  // Clock
  input  wire logic        sys_clk,
  // Register port
  output logic             regRead,
  output logic             regWrite,
  output logic [4:0]       regIndex,
  output logic [31:0]      regWdata,
  input  wire logic [31:0] regRdata,
  input  wire logic        regRvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    regRead = 1'b0;
    regWrite = 1'b0;
    regIndex = 5'h1F;
    regWdata = 32'h0000_0000;
  end

  // One whole word per register, control bits in low byte
  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    @(negedge sys_clk);
    regIndex = idx;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
    regWdata = ~d; // Released data no longer shows the word
  endtask

  // Answer sampled in the cycle after the strobe
  task automatic rd(input logic [4:0] idx, output logic [31:0] d,
                    output logic v);
    @(negedge sys_clk);
    regIndex = idx;
    regRead = 1'b1;
    @(negedge sys_clk);
    regRead = 1'b0;
    regIndex = ~idx;
    d = regRdata;
    v = regRvalid;
  endtask
endmodule
`default_nettype wire
